//--- hdl/lamp_inverter_fault_supervisor.sv
// lamp inverter supervisor: burst period, commutation, faults, shutdown, avalon registers
//
// How it works
// [RULE1] burst period equals 128 sync pulses
// [RULE2] sync source stays within 32 to 100 kHz
// [RULE3] alternate low-side drivers on each zero crossing
// [RULE4] reset returns every register to default
// [RULE5] undervoltage keeps buck driver off
// [RULE6] shutdown stops everything but registers and bus
// [RULE7] bus works and registers hold in shutdown
// [RULE8] entering shutdown clears both fault latches
// [RULE9] shutdown by register write or pin; the register write only counts in digital mode, the pin in every mode
// [RULE10] no lamp current for 2 s latches fault
// [RULE11] sense pulses under 200 ns are ignored
// [RULE12] sample amplifier low at each period end
// [RULE13] short fault after over 64 consecutive low samples
// [RULE14] short fault freezes one driver on, latches off
// [RULE15] health flag changes 2 s after fault
// [RULE16] short counter clears on high sample, shutdown
// [RULE17] pin is suspend digitally, shutdown in analog
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module lamp_inverter_fault_supervisor #(
    parameter int LAMP_TIMEOUT_CYC = lamp_sup_pkg::LAMP_TIMEOUT_CYC,
    parameter int HEALTH_DELAY_CYC = lamp_sup_pkg::HEALTH_DELAY_CYC
) (
    // clock and power-on reset
    input wire logic clk_sys,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [2:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // asynchronous pins
    input wire lamp_sup_pkg::pin_in_type pins,
    // power stage drives and status
    output logic low_side_drive_a,
    output logic low_side_drive_b,
    output logic buck_drive_en,
    output logic burst_dimming_tick,
    output logic lamp_health_flag,
    output logic irq
);

    localparam int LT_W = $clog2(LAMP_TIMEOUT_CYC + 1);
    localparam int HD_W = $clog2(HEALTH_DELAY_CYC + 1);
    localparam int BC_W = $clog2(lamp_sup_pkg::BURST_PULSES);
    localparam int SC_W = $clog2(lamp_sup_pkg::SHORT_PERIODS + 1);
    localparam int FC_W = $clog2(lamp_sup_pkg::SENSE_FILT_CYC + 1);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (LAMP_TIMEOUT_CYC < 2 || HEALTH_DELAY_CYC < 2) begin : g_bad_timing
        $error("timeout counts must be at least 2 cycles");
    end

    // ------------------------------------------------------------
    // pin synchronisation and edges
    // ------------------------------------------------------------
    lamp_sup_pkg::pin_in_type pins_s;
    logic sync_d_r;
    logic zc_d_r;
    logic sync_rise;
    logic zc_rise;

    pin_sync #(.WIDTH($bits(lamp_sup_pkg::pin_in_type))) u_pin_sync (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .din(pins),
        .dout(pins_s)
    );

    // edge detectors look only at the second synchroniser stage
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sync_d_r <= 1'b0;
            zc_d_r <= 1'b0;
        end else begin
            sync_d_r <= pins_s.sync_pulse;
            zc_d_r <= pins_s.zero_cross;
        end
    end

    assign sync_rise = pins_s.sync_pulse & ~sync_d_r;
    assign zc_rise = pins_s.zero_cross & ~zc_d_r;

    // ------------------------------------------------------------
    // bus slave and software registers
    // ------------------------------------------------------------
    logic ctrl_shdn_r;
    logic [lamp_sup_pkg::IRQ_W-1:0] irq_pend_r;
    logic [lamp_sup_pkg::IRQ_W-1:0] irq_mask_r;
    logic [lamp_sup_pkg::IRQ_W-1:0] irq_clr;
    logic [lamp_sup_pkg::IRQ_W-1:0] events;
    logic [31:0] status_word;
    logic wr_acc;
    logic shutdown_r;
    logic lamp_fault_r;
    logic short_fault_r;

    // a write lands on the edge where waitrequest is seen low
    assign wr_acc = write & ~waitrequest;
    assign irq_clr = (wr_acc && address == lamp_sup_pkg::REG_IRQ_STATUS) ?
                     writedata[lamp_sup_pkg::IRQ_W-1:0] : '0;

    always_comb begin
        status_word = '0;
        status_word[lamp_sup_pkg::ST_SHDN_BIT] = shutdown_r;
        status_word[lamp_sup_pkg::ST_LAMP_BIT] = lamp_fault_r;
        status_word[lamp_sup_pkg::ST_SHORT_BIT] = short_fault_r;
        status_word[lamp_sup_pkg::ST_HEALTH_BIT] = lamp_health_flag;
        status_word[lamp_sup_pkg::ST_UVLO_BIT] = pins_s.uvlo;
        status_word[lamp_sup_pkg::ST_MODE_LSB +: 2] = pins_s.mode;
    end

    // one wait cycle per access, independent of shutdown
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            waitrequest <= 1'b1;
            readdata <= lamp_sup_pkg::READ_UNMAPPED;
        end else begin
            waitrequest <= ~((read | write) & waitrequest); // RULE7
            if (read && waitrequest) begin
                unique case (address)
                    lamp_sup_pkg::REG_CTRL: readdata <= {31'h0000_0000, ctrl_shdn_r};
                    lamp_sup_pkg::REG_STATUS: readdata <= status_word;
                    lamp_sup_pkg::REG_IRQ_STATUS: readdata <= {28'h000_0000, irq_pend_r};
                    lamp_sup_pkg::REG_IRQ_MASK: readdata <= {28'h000_0000, irq_mask_r};
                    default: readdata <= lamp_sup_pkg::READ_UNMAPPED;
                endcase
            end
        end
    end

    // writable registers keep their contents through shutdown
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ctrl_shdn_r <= 1'b0; // RULE4
            irq_mask_r <= lamp_sup_pkg::IRQ_MASK_RST;
        end else if (wr_acc) begin
            if (address == lamp_sup_pkg::REG_CTRL) begin
                ctrl_shdn_r <= writedata[lamp_sup_pkg::CTRL_SHDN_BIT];
            end
            if (address == lamp_sup_pkg::REG_IRQ_MASK) begin
                irq_mask_r <= writedata[lamp_sup_pkg::IRQ_W-1:0];
            end
        end
    end

    // sticky events; a new event beats a same-cycle clear
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            irq_pend_r <= '0;
            irq <= 1'b0;
        end else begin
            irq_pend_r <= (irq_pend_r & ~irq_clr) | events;
            irq <= |(irq_pend_r & irq_mask_r);
        end
    end

    // ------------------------------------------------------------
    // shutdown control
    // ------------------------------------------------------------
    logic digital_mode;
    logic active;

    assign digital_mode = (pins_s.mode == lamp_sup_pkg::MODE_DIGITAL);
    assign active = ~shutdown_r & ~lamp_fault_r & ~short_fault_r;

    // pin is suspend in digital mode and plain shutdown in analog modes;
    // the register bit only counts where the digital interface is selected
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shutdown_r <= 1'b0;
        end else if (digital_mode) begin
            shutdown_r <= ctrl_shdn_r | pins_s.shdn_pin; // RULE9 RULE17
        end else begin
            shutdown_r <= pins_s.shdn_pin; // RULE17
        end
    end

    // ------------------------------------------------------------
    // burst period from the sync pulse train
    // ------------------------------------------------------------
    logic [BC_W-1:0] burst_cnt_r;

    // period length rests on the external rate staying in range (RULE2)
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            burst_cnt_r <= '0;
            burst_dimming_tick <= 1'b0;
        end else begin
            burst_dimming_tick <= 1'b0;
            if (shutdown_r) begin
                burst_cnt_r <= '0; // RULE6
            end else if (sync_rise) begin
                if (burst_cnt_r == BC_W'(lamp_sup_pkg::BURST_PULSES - 1)) begin
                    burst_cnt_r <= '0; // RULE1
                    burst_dimming_tick <= 1'b1;
                end else begin
                    burst_cnt_r <= burst_cnt_r + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // lamp-out detection
    // ------------------------------------------------------------
    logic [FC_W-1:0] filt_cnt_r;
    logic lamp_seen;
    logic [LT_W-1:0] lamp_timer_r;

    // a sense pulse must stay high for the filter time to count
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            filt_cnt_r <= '0;
        end else if (!pins_s.lamp_sense) begin
            filt_cnt_r <= '0;
        end else if (!lamp_seen) begin
            filt_cnt_r <= filt_cnt_r + 1'b1; // RULE11
        end
    end

    assign lamp_seen = (filt_cnt_r == FC_W'(lamp_sup_pkg::SENSE_FILT_CYC));

    // window restarts each time lamp current is seen
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            lamp_timer_r <= '0;
            lamp_fault_r <= 1'b0;
        end else if (shutdown_r) begin
            lamp_timer_r <= '0;
            lamp_fault_r <= 1'b0; // RULE8
        end else if (!active || lamp_seen) begin
            lamp_timer_r <= '0;
        end else if (lamp_timer_r == LT_W'(LAMP_TIMEOUT_CYC - 1)) begin
            lamp_fault_r <= 1'b1; // RULE10
        end else begin
            lamp_timer_r <= lamp_timer_r + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // buck-switch short detection
    // ------------------------------------------------------------
    logic [SC_W-1:0] short_cnt_r;

    // a single high sample breaks the run of low samples
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            short_cnt_r <= '0;
            short_fault_r <= 1'b0;
        end else if (shutdown_r) begin
            short_cnt_r <= '0; // RULE16
            short_fault_r <= 1'b0; // RULE8
        end else if (burst_dimming_tick && active) begin
            if (!pins_s.amp_low) begin // RULE12
                short_cnt_r <= '0; // RULE16
            end else if (short_cnt_r == SC_W'(lamp_sup_pkg::SHORT_PERIODS)) begin
                short_fault_r <= 1'b1; // RULE13
            end else begin
                short_cnt_r <= short_cnt_r + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // commutation and buck drive
    // ------------------------------------------------------------
    // on a short one side stays on so a shorted buck switch blows the fuse
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            low_side_drive_a <= 1'b0;
            low_side_drive_b <= 1'b0;
        end else if (shutdown_r || lamp_fault_r) begin
            low_side_drive_a <= 1'b0; // RULE6
            low_side_drive_b <= 1'b0;
        end else if (short_fault_r) begin
            if (!low_side_drive_b) begin
                low_side_drive_a <= 1'b1; // RULE14
            end
        end else if (!low_side_drive_a && !low_side_drive_b) begin
            low_side_drive_a <= 1'b1;
        end else if (zc_rise) begin
            low_side_drive_a <= low_side_drive_b; // RULE3
            low_side_drive_b <= low_side_drive_a;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            buck_drive_en <= 1'b0;
        end else begin
            buck_drive_en <= active & ~pins_s.uvlo; // RULE5 RULE14
        end
    end

    // ------------------------------------------------------------
    // delayed health flag and event sources
    // ------------------------------------------------------------
    logic [HD_W-1:0] health_cnt_r;
    logic [2:0] prev_r;

    // flag drops only after a fault latch has been set for the delay
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            health_cnt_r <= '0;
            lamp_health_flag <= 1'b1;
        end else if (shutdown_r) begin
            health_cnt_r <= '0;
            lamp_health_flag <= 1'b1;
        end else if ((lamp_fault_r || short_fault_r) && lamp_health_flag) begin
            if (health_cnt_r == HD_W'(HEALTH_DELAY_CYC - 1)) begin
                lamp_health_flag <= 1'b0; // RULE15
            end else begin
                health_cnt_r <= health_cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            prev_r <= 3'h7;
        end else begin
            prev_r <= {lamp_health_flag, short_fault_r, lamp_fault_r};
        end
    end

    always_comb begin
        events = '0;
        events[lamp_sup_pkg::IRQ_LAMP_BIT] = lamp_fault_r & ~prev_r[0];
        events[lamp_sup_pkg::IRQ_SHORT_BIT] = short_fault_r & ~prev_r[1];
        events[lamp_sup_pkg::IRQ_HEALTH_BIT] = prev_r[2] & ~lamp_health_flag;
        events[lamp_sup_pkg::IRQ_PERIOD_BIT] = burst_dimming_tick;
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_burst_period_end: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE1
        (sync_rise && !shutdown_r
         && burst_cnt_r == BC_W'(lamp_sup_pkg::BURST_PULSES - 1))
        |=> burst_dimming_tick)
        else $error("burst period did not end after 128 pulses");

    a_drivers_alternate: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE3
        (zc_rise && active && low_side_drive_a && !low_side_drive_b)
        |=> (low_side_drive_b && !low_side_drive_a))
        else $error("drivers did not swap on zero crossing");

    a_uvlo_buck_off: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE5
        pins_s.uvlo |=> !buck_drive_en)
        else $error("buck driver on during undervoltage");

    a_shutdown_quiet: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE6
        shutdown_r [*2] |-> !low_side_drive_a && !low_side_drive_b && !buck_drive_en)
        else $error("drive active in shutdown");

    a_bus_answers: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE7
        ((read || write) && waitrequest) |=> !waitrequest)
        else $error("bus access not answered in one cycle");

    a_shutdown_clears: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE8
        shutdown_r |=> !lamp_fault_r && !short_fault_r && short_cnt_r == '0)
        else $error("fault latch survived shutdown");

    a_register_shdn: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE9
        (digital_mode && ctrl_shdn_r) |=> shutdown_r)
        else $error("register shutdown ignored");

    a_lamp_timeout: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE10
        $rose(lamp_fault_r) |-> $past(lamp_timer_r) == LT_W'(LAMP_TIMEOUT_CYC - 1))
        else $error("lamp fault at wrong time");

    // the filter count only holds its top value after two high samples in a row
    a_sense_filter: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE11
        lamp_seen |-> $past(pins_s.lamp_sense) && $past(pins_s.lamp_sense, 2))
        else $error("short sense pulse accepted");

    a_short_count: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE13
        $rose(short_fault_r)
        |-> $past(short_cnt_r) == SC_W'(lamp_sup_pkg::SHORT_PERIODS) && $past(pins_s.amp_low))
        else $error("short fault without 65 low samples");

    a_short_hold_on: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE14
        (short_fault_r && !shutdown_r && !lamp_fault_r) [*2]
        |-> (low_side_drive_a ^ low_side_drive_b) && !buck_drive_en)
        else $error("short fault did not freeze one driver on");

    a_health_delay: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE15
        $fell(lamp_health_flag) |-> $past(health_cnt_r) == HD_W'(HEALTH_DELAY_CYC - 1))
        else $error("health flag changed before delay");

    a_short_reset: assert property (@(posedge clk_sys) disable iff (!resetn) // RULE16
        (burst_dimming_tick && active && !pins_s.amp_low) |=> short_cnt_r == '0)
        else $error("short counter not cleared by high sample");

    a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
        irq == $past(|(irq_pend_r & irq_mask_r)))
        else $error("interrupt output disagrees with pending and mask");

endmodule

//--- hdl/lamp_sup_pkg.sv
// shared constants and carrier types for the lamp inverter fault supervisor
package lamp_sup_pkg;

    // ------------------------------------------------------------
    // timebase
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 10_000;
    localparam int CLK_PERIOD_NS = 100;

    // ------------------------------------------------------------
    // timing figures and derived cycle counts
    // ------------------------------------------------------------
    localparam int BURST_PULSES = 128;
    localparam int SENSE_FILT_NS = 200;
    // least time, so round up
    localparam int SENSE_FILT_CYC = (SENSE_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LAMP_TIMEOUT_MS = 2000;
    localparam int LAMP_TIMEOUT_CYC = LAMP_TIMEOUT_MS * CLK_KHZ;
    localparam int HEALTH_DELAY_MS = 2000;
    localparam int HEALTH_DELAY_CYC = HEALTH_DELAY_MS * CLK_KHZ;
    localparam int SHORT_PERIODS = 64;

    // ------------------------------------------------------------
    // register word indexes on the avalon address
    // ------------------------------------------------------------
    localparam logic [2:0] REG_CTRL = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_IRQ_STATUS = 3'h2;
    localparam logic [2:0] REG_IRQ_MASK = 3'h3;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_SHDN_BIT = 0;
    localparam int ST_SHDN_BIT = 0;
    localparam int ST_LAMP_BIT = 1;
    localparam int ST_SHORT_BIT = 2;
    localparam int ST_HEALTH_BIT = 3;
    localparam int ST_UVLO_BIT = 4;
    localparam int ST_MODE_LSB = 5;
    localparam int IRQ_LAMP_BIT = 0;
    localparam int IRQ_SHORT_BIT = 1;
    localparam int IRQ_HEALTH_BIT = 2;
    localparam int IRQ_PERIOD_BIT = 3;
    localparam int IRQ_W = 4;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

    // interface mode strap codes
    localparam logic [1:0] MODE_DIGITAL = 2'h0;
    localparam logic [1:0] MODE_ANALOG_REF = 2'h1;
    localparam logic [1:0] MODE_ANALOG_GND = 2'h2;

    // asynchronous pin inputs, synchronised as one bundle
    typedef struct packed {
        logic [1:0] mode;
        logic shdn_pin;
        logic uvlo;
        logic amp_low;
        logic lamp_sense;
        logic zero_cross;
        logic sync_pulse;
    } pin_in_type;

endpackage

//--- hdl/pin_sync.sv
// two flip-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // pins in, synchronised levels out
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_r;

    // first stage is read by the second stage only
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end

endmodule

//--- verification/stage_model.sv
// power stage and sense pin model facing the supervisor
`timescale 1ns/1ps
module stage_model #(
    parameter int SYNC_HALF = 3
) (
    // clock
    input wire logic clk_sys,
    // scenario controls
    input wire logic lamp_ok,
    input wire logic glitch,
    input wire logic amp_low,
    input wire logic uvlo,
    input wire logic shdn_pin,
    input wire logic [1:0] mode,
    // sense pins
    output lamp_sup_pkg::pin_in_type pins
);
    int cnt = 0;

    // free counter, stepped just after each edge
    always @(posedge clk_sys) begin
        cnt <= cnt + 1;
    end

    // sync runs far above its legal span only to keep the run short
    assign pins.sync_pulse = ((cnt / SYNC_HALF) % 2) == 1;
    assign pins.zero_cross = (cnt % 20) == 0;
    // lamp pulses are 300 ns wide; a glitch is a lone 100 ns spike
    assign pins.lamp_sense = lamp_ok ? (cnt % 10) < 3 : glitch && (cnt % 10) == 0;
    assign pins.amp_low = amp_low;
    assign pins.uvlo = uvlo;
    assign pins.shdn_pin = shdn_pin;
    assign pins.mode = mode;
endmodule

//--- verification/tb_top.sv
// self-checking bench for the lamp inverter supervisor
`timescale 1ns/1ps
module tb_top;
    localparam int SH = 3;
    logic clk_sys = 0;
    logic resetn = 0;
    logic [2:0] address = 3'h0;
    logic read = 0;
    logic write = 0;
    logic [31:0] writedata = 32'h0000_0000;
    logic [31:0] readdata;
    logic waitrequest;
    lamp_sup_pkg::pin_in_type pins;
    logic drv_a, drv_b, buck, tick, health, irq;
    logic lamp_ok = 1;
    logic glitch = 0;
    logic amp_low = 0;
    logic uvlo = 0;
    logic shdn_pin = 0;
    logic [1:0] mode = 2'h0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    int seed = 17;
    int n;
    logic pa;
    logic [31:0] rm;

    always #50 clk_sys = ~clk_sys;

    lamp_inverter_fault_supervisor #(.LAMP_TIMEOUT_CYC(50), .HEALTH_DELAY_CYC(30)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .pins(pins), .low_side_drive_a(drv_a),
        .low_side_drive_b(drv_b), .buck_drive_en(buck), .burst_dimming_tick(tick),
        .lamp_health_flag(health), .irq(irq));

    stage_model #(.SYNC_HALF(SH)) model (
        .clk_sys(clk_sys), .lamp_ok(lamp_ok), .glitch(glitch), .amp_low(amp_low),
        .uvlo(uvlo), .shdn_pin(shdn_pin), .mode(mode), .pins(pins));

    // one compare for every result, masked to the bits that matter
    task chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
        total_checks++;
        if ((got & m) !== (exp & m)) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // avalon access held until waitrequest is sampled low
    task bus(input logic rd, input logic [2:0] a, input logic [31:0] d, input logic [31:0] m);
        read <= rd;
        write <= !rd;
        address <= a;
        writedata <= d;
        if (rd) begin
            exp_q.push_back(d);
            msk_q.push_back(m);
        end
        @(posedge clk_sys);
        while (waitrequest !== 1'b0) @(posedge clk_sys);
        read <= 0;
        write <= 0;
        @(posedge clk_sys);
    endtask

    task wr(input logic [2:0] a, input logic [31:0] d);
        bus(0, a, d, 0);
    endtask

    task rs(input logic [31:0] e, input logic [31:0] m);
        bus(1, lamp_sup_pkg::REG_STATUS, e, m);
    endtask

    task cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    task ticks(input int k);
        repeat (k) begin
            @(posedge clk_sys);
            while (tick !== 1'b1) @(posedge clk_sys);
        end
    endtask

    // read data stand at the edge where waitrequest is low; oldest note first
    always @(posedge clk_sys) begin
        if (read && waitrequest === 1'b0 && exp_q.size() > 0)
            chk(readdata, exp_q.pop_front(), msk_q.pop_front());
    end

    task final_report();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard: the sequence needs about 70k cycles
    initial begin
        cyc(90000);
        error_cnt++;
        $display("[FAIL] %0t timeout", $time);
        final_report();
    end

    // main sequence
    initial begin
        cyc(16);
        resetn <= 1;
        cyc(8);
        rs(32'h0000_0008, 32'h0000_007f);
        bus(1, lamp_sup_pkg::REG_IRQ_STATUS, 32'h0000_0000, 32'hffff_fff7);
        bus(1, lamp_sup_pkg::REG_IRQ_MASK, 32'h0000_0000, 32'hffff_ffff);
        bus(1, {1'b1, 2'($random(seed))}, 32'h0000_0000, 32'hffff_ffff);
        $display("test reset done");
        n = 0;
        pa = drv_a;
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_sys);
            chk(drv_a ^ drv_b, 1, 1);
            n += (drv_a !== pa);
            pa = drv_a;
        end
        chk(n, 3, 32'hffff_ffff);
        chk(buck, 1, 1);
        ticks(1);
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (tick !== 1'b1);
        chk(n, lamp_sup_pkg::BURST_PULSES * 2 * SH, 32'hffff_ffff);
        bus(1, lamp_sup_pkg::REG_IRQ_STATUS, 32'h0000_0008, 32'h0000_0008);
        uvlo <= 1;
        cyc(6);
        chk(buck, 0, 1);
        rs(32'h0000_0010, 32'h0000_0010);
        uvlo <= 0;
        $display("test drive done");
        wr(lamp_sup_pkg::REG_IRQ_STATUS, 32'h0000_000f);
        wr(lamp_sup_pkg::REG_IRQ_MASK, 32'h0000_0001);
        lamp_ok <= 0;
        glitch <= 1;
        cyc(30);
        rs(32'h0000_0000, 32'h0000_0002);
        cyc(30);
        rs(32'h0000_000a, 32'h0000_000f);
        chk({drv_a, drv_b, buck}, 0, 7);
        chk(irq, 1, 1);
        wr(lamp_sup_pkg::REG_IRQ_MASK, 32'h0000_0000);
        cyc(2);
        chk(irq, 0, 1);
        cyc(40);
        chk(health, 0, 1);
        bus(1, lamp_sup_pkg::REG_IRQ_STATUS, 32'h0000_0005, 32'h0000_0007);
        wr(lamp_sup_pkg::REG_IRQ_STATUS, 32'h0000_000f);
        bus(1, lamp_sup_pkg::REG_IRQ_STATUS, 32'h0000_0000, 32'h0000_0007);
        $display("test lamp fault done");
        rm = 32'($random(seed)) & 32'h0000_000f;
        wr(lamp_sup_pkg::REG_IRQ_MASK, rm);
        wr(lamp_sup_pkg::REG_CTRL, 32'h0000_0001);
        cyc(5);
        rs(32'h0000_0009, 32'h0000_000f);
        chk({drv_a, drv_b, buck}, 0, 7);
        bus(1, lamp_sup_pkg::REG_IRQ_MASK, rm, 32'hffff_ffff);
        wr(lamp_sup_pkg::REG_IRQ_MASK, 32'h0000_0000);
        lamp_ok <= 1;
        glitch <= 0;
        mode <= lamp_sup_pkg::MODE_ANALOG_REF;
        wr(lamp_sup_pkg::REG_CTRL, 32'h0000_0000);
        cyc(8);
        wr(lamp_sup_pkg::REG_CTRL, 32'h0000_0001);
        cyc(5);
        rs(32'h0000_0028, 32'h0000_007f);
        shdn_pin <= 1;
        mode <= lamp_sup_pkg::MODE_ANALOG_GND;
        cyc(6);
        rs(32'h0000_0049, 32'h0000_007f);
        chk({drv_a, drv_b}, 0, 3);
        shdn_pin <= 0;
        wr(lamp_sup_pkg::REG_CTRL, 32'h0000_0000);
        mode <= lamp_sup_pkg::MODE_DIGITAL;
        cyc(8);
        $display("test shutdown done");
        ticks(1);
        amp_low <= 1;
        ticks(20);
        amp_low <= 0;
        ticks(2);
        amp_low <= 1;
        ticks(64);
        cyc(4);
        rs(32'h0000_0000, 32'h0000_0004);
        ticks(1);
        cyc(5);
        rs(32'h0000_0004, 32'h0000_0004);
        chk(buck, 0, 1);
        pa = drv_a;
        cyc(40);
        chk({drv_a | drv_b, drv_a}, {1'b1, pa}, 3);
        $display("test short fault done");
        wr(lamp_sup_pkg::REG_IRQ_MASK, 32'h0000_000f);
        // second power-on reset in mid-run: latched short and mask must go back
        resetn <= 0;
        cyc(2);
        resetn <= 1;
        cyc(8);
        rs(32'h0000_0008, 32'h0000_007f);
        bus(1, lamp_sup_pkg::REG_IRQ_MASK, 32'h0000_0000, 32'hffff_ffff);
        $display("test second reset done");
        final_report();
    end
endmodule
